// ### sfrpe_chk.sv
`timescale 1ns/1ps
// ********
// Port checker
// ********
module sfrpe_chk (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Watched ports
  input wire logic                    selectN,
  input wire logic                    misoOeN,
  input wire logic                    statusWriteBusy,
  input wire logic [2:0]              protectLevel,
  input wire logic                    writeUnlockLatch,
  input wire logic                    cycleBusyFlag,
  input wire logic [22:0]             memRdAddr,
  input wire logic                    memWrValid,
  input wire logic                    memWrReady,
  input wire sfrpe_pkg::sfrpe_wr_t    memWr,
  input wire logic                    eraseStart,
  input wire sfrpe_pkg::sfrpe_erase_t eraseReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_oe_release: assert property (selectN [*5] |-> misoOeN)
    else $error("output driven while deselected");
  a_oe_select: assert property ($fell(misoOeN) |-> !selectN)
    else $error("output enabled without select");
  a_status_busy: assert property (statusWriteBusy |-> cycleBusyFlag)
    else $error("status write not busy");
  a_read_frozen: assert property (cycleBusyFlag && $past(cycleBusyFlag) |-> $stable(memRdAddr))
    else $error("read address moved while busy");
  a_busy_latch: assert property ($rose(cycleBusyFlag) && !statusWriteBusy |-> !writeUnlockLatch)
    else $error("latch not cleared at cycle start");
  a_wr_hold: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWr))
    else $error("program word dropped under stall");
  a_wr_busy: assert property (memWrValid |-> cycleBusyFlag)
    else $error("program word outside cycle");
  a_erase_pulse: assert property (eraseStart |-> cycleBusyFlag ##1 !eraseStart)
    else $error("erase start not a busy pulse");
  a_whole_prot: assert property (eraseStart && eraseReq.whole |-> protectLevel == 3'h0)
    else $error("whole erase under protection");
  a_sector_prot: assert property (eraseStart |-> protectLevel != 3'h7)
    else $error("erase with all protected");
  a_sector_top: assert property (eraseStart && !eraseReq.whole && protectLevel != 3'h0
    |-> eraseReq.sector != 7'h7F)
    else $error("erase of protected top sector");
endmodule

bind sfrpe_core sfrpe_chk u_chk (.clk, .rst, .selectN, .misoOeN, .statusWriteBusy, .protectLevel, .writeUnlockLatch,
  .cycleBusyFlag, .memRdAddr, .memWrValid, .memWrReady, .memWr, .eraseStart, .eraseReq);

// ### sfrpe_core.sv
// Behaviour
// - Fast read takes opcode, three address bytes, one dummy byte, sampled on rising clock.
// - After the dummy byte, memory data leaves on falling clock edges from the address.
// - Read address increments per byte and rolls over to zero indefinitely.
// - Raising select ends a read at any time and releases the output.
// - Fast read is rejected while any self-timed cycle runs; the cycle continues.
// - Page write and erases need the write-unlock latch set beforehand.
// - Page write increments only the low eight address bits, wrapping within the page.
// - Beyond 256 data bytes, only the last 256 received are programmed.
// - Fewer than 256 bytes program only addressed bytes; others stay unchanged.
// - Page write runs only if select rises exactly on a data byte boundary.
// - Valid page write starts a timed cycle with busy set and unlock latch cleared.
// - Page write or sector erase into a protected area is not executed.
// - Host keeps select low for the whole write or erase sequence.
// - Sector erase is opcode plus three address bytes, select rising right after.
// - Valid sector erase starts a timed cycle, busy set, unlock latch cleared.
// - Whole erase is opcode alone with select rising right after; timed cycle follows.
// - Whole erase runs only when all three protect bits are zero.
// - The top address bit is ignored for read, page write and erase addressing.
// - Signature read takes three dummy bytes then sends the 8-bit signature on falls.
// - Continued clocking repeats the signature byte.
// - Select rising during signature read returns to standby at once.
`timescale 1ns/1ps

// ****************************************
// Word FIFO
// ****************************************
module sfrpe_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0]   wrPtr;
  logic [PTR_W:0]   rdPtr;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (wrPtr[PTR_W] == rdPtr[PTR_W]) || (wrPtr[PTR_W-1:0] != rdPtr[PTR_W-1:0]);
  assign outValid = wrPtr != rdPtr;
  assign outData  = store[rdPtr[PTR_W-1:0]];
  assign doWrite  = inValid & inReady;
  assign doRead   = outValid & outReady;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      store[wrPtr[PTR_W-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Command sequencer
// ****************************************
module sfrpe_core #(
  parameter int          PROG_CYCLES   = sfrpe_pkg::PROG_TIME_NS / sfrpe_pkg::CLK_PERIOD_NS,
  parameter int          SECTOR_CYCLES = sfrpe_pkg::SECTOR_TIME_NS / sfrpe_pkg::CLK_PERIOD_NS,
  parameter int          WHOLE_CYCLES  = sfrpe_pkg::WHOLE_TIME_NS / sfrpe_pkg::CLK_PERIOD_NS,
  parameter logic [7:0]  SIGNATURE     = sfrpe_pkg::SIGNATURE_DEFAULT,
  parameter int          FIFO_DEPTH    = sfrpe_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Serial pins
  input  wire logic                          sclkPin,
  input  wire logic                          selectN,
  input  wire logic                          mosiPin,
  output logic                               misoOut,
  output logic                               misoOeN,
  // Status bits
  input  wire logic                          writeUnlockSet,
  input  wire logic                          statusWriteBusy,
  input  wire logic [2:0]                    protectLevel,
  output logic                               writeUnlockLatch,
  output logic                               cycleBusyFlag,
  // Array read port
  output logic      [sfrpe_pkg::ADDR_W-1:0]  memRdAddr,
  input  wire logic [7:0]                    memRdData,
  // Array program stream
  output logic                               memWrValid,
  input  wire logic                          memWrReady,
  output sfrpe_pkg::sfrpe_wr_t               memWr,
  // Array erase request
  output logic                               eraseStart,
  output sfrpe_pkg::sfrpe_erase_t            eraseReq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pinRaw;
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  logic       sclkPrev;
  logic       selPrev;

  assign pinRaw = {sclkPin, selectN, mosiPin};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or posedge rst) begin
      // Synchronisers start at the idle pin levels, so no false select edge follows reset.
      if (rst) begin
        pinMeta[i] <= sfrpe_pkg::PIN_IDLE[i];
        pinSync[i] <= sfrpe_pkg::PIN_IDLE[i];
      end else begin
        pinMeta[i] <= pinRaw[i];
        pinSync[i] <= pinMeta[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkPrev <= sfrpe_pkg::PIN_IDLE[2];
      selPrev  <= sfrpe_pkg::PIN_IDLE[1];
    end else begin
      sclkPrev <= pinSync[2];
      selPrev  <= pinSync[1];
    end
  end

  logic deselected;
  logic sclkRise;
  logic sclkFall;
  logic selRise;

  assign deselected = pinSync[1];
  assign sclkRise   = pinSync[2] & ~sclkPrev & ~deselected;
  assign sclkFall   = ~pinSync[2] & sclkPrev & ~deselected;
  assign selRise    = pinSync[1] & ~selPrev;

  // ****************************************
  // Input shifting
  // ****************************************
  sfrpe_pkg::sfrpe_state_t state;
  sfrpe_pkg::sfrpe_cycle_t cycState;
  logic [2:0]  bitCnt;
  logic [1:0]  byteCnt;
  logic [6:0]  shiftIn;
  logic [23:0] addrReg;
  logic [7:0]  opcode;
  logic [7:0]  inByte;
  logic        byteDone;
  logic        busy;

  assign inByte        = {shiftIn, pinSync[0]};
  assign byteDone      = sclkRise & (bitCnt == sfrpe_pkg::BIT_LAST);
  assign busy          = (cycState != sfrpe_pkg::CY_IDLE) | statusWriteBusy;
  assign cycleBusyFlag = busy;

  // Every bit is sampled on a rising serial clock.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt  <= '0;
      shiftIn <= '0;
    end else if (deselected) begin
      bitCnt  <= '0;
    end else if (sclkRise) begin
      bitCnt  <= bitCnt + 1'b1;
      shiftIn <= inByte[6:0];
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  logic pageStart;
  logic addrLast;

  assign addrLast  = byteDone & (state == sfrpe_pkg::ST_ADDR) & (byteCnt == sfrpe_pkg::ADDR_LAST_BYTE);
  assign pageStart = byteDone & (state == sfrpe_pkg::ST_OPCODE) & (inByte == sfrpe_pkg::OP_PAGE_WRITE)
                     & writeUnlockLatch & ~busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= sfrpe_pkg::ST_OPCODE;
      byteCnt <= '0;
      opcode  <= '0;
      addrReg <= '0;
    end else if (deselected) begin
      state   <= sfrpe_pkg::ST_OPCODE;
      byteCnt <= '0;
    end else if (byteDone) begin
      case (state)
        sfrpe_pkg::ST_OPCODE: begin
          opcode <= inByte;
          case (inByte)
            sfrpe_pkg::OP_FAST_READ: begin
              state <= busy ? sfrpe_pkg::ST_IGNORE : sfrpe_pkg::ST_ADDR;
            end
            sfrpe_pkg::OP_PAGE_WRITE, sfrpe_pkg::OP_SECTOR_CLEAR: begin
              state <= (writeUnlockLatch & ~busy) ? sfrpe_pkg::ST_ADDR : sfrpe_pkg::ST_IGNORE;
            end
            sfrpe_pkg::OP_WHOLE_CLEAR: begin
              state <= (writeUnlockLatch & ~busy) ? sfrpe_pkg::ST_WHOLE_WAIT : sfrpe_pkg::ST_IGNORE;
            end
            sfrpe_pkg::OP_SIGNATURE: begin
              state <= sfrpe_pkg::ST_SIG_DUMMY;
            end
            default: begin
              state <= sfrpe_pkg::ST_IGNORE;
            end
          endcase
        end
        sfrpe_pkg::ST_ADDR: begin
          addrReg <= {addrReg[15:0], inByte};
          byteCnt <= byteCnt + 1'b1;
          if (byteCnt == sfrpe_pkg::ADDR_LAST_BYTE) begin
            byteCnt <= '0;
            case (opcode)
              sfrpe_pkg::OP_FAST_READ:  state <= sfrpe_pkg::ST_DUMMY;
              sfrpe_pkg::OP_PAGE_WRITE: state <= sfrpe_pkg::ST_PROG_DATA;
              default:                  state <= sfrpe_pkg::ST_SECTOR_WAIT;
            endcase
          end
        end
        sfrpe_pkg::ST_DUMMY: begin
          state <= sfrpe_pkg::ST_READ_OUT;
        end
        sfrpe_pkg::ST_SIG_DUMMY: begin
          byteCnt <= byteCnt + 1'b1;
          if (byteCnt == sfrpe_pkg::ADDR_LAST_BYTE) begin
            state <= sfrpe_pkg::ST_SIG_OUT;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end else if (sclkRise && (state == sfrpe_pkg::ST_SECTOR_WAIT || state == sfrpe_pkg::ST_WHOLE_WAIT)) begin
      state <= sfrpe_pkg::ST_IGNORE;
    end
  end

  // ****************************************
  // Page buffer
  // ****************************************
  logic [7:0]                          pageBuf [sfrpe_pkg::PAGE_BYTES];
  logic [sfrpe_pkg::PAGE_BYTES-1:0]    pageMask;
  logic [sfrpe_pkg::PAGE_IDX_W-1:0]    pageIdx;
  logic                                dataSeen;
  logic                                progWrite;

  assign progWrite = byteDone & (state == sfrpe_pkg::ST_PROG_DATA);

  // Later bytes overwrite earlier ones at the same index, so the last 256 survive.
  always_ff @(posedge clk) begin
    if (progWrite) begin
      pageBuf[pageIdx] <= inByte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageMask <= '0;
      pageIdx  <= '0;
      dataSeen <= 1'b0;
    end else if (pageStart) begin
      pageMask <= '0;
      dataSeen <= 1'b0;
    end else if (addrLast) begin
      pageIdx  <= inByte;
    end else if (progWrite) begin
      pageMask[pageIdx] <= 1'b1;
      pageIdx  <= pageIdx + 1'b1;
      dataSeen <= 1'b1;
    end
  end

  // ****************************************
  // Launch checks on select rising
  // ****************************************
  logic [7:0] protCount;
  logic       targetProtected;
  logic       startProg;
  logic       startSector;
  logic       startWhole;

  always_comb begin
    protCount = '0;
    if (protectLevel == sfrpe_pkg::PROT_ALL_LEVEL) begin
      protCount = sfrpe_pkg::SECTOR_COUNT;
    end else if (protectLevel != 3'h0) begin
      protCount = 8'h01 << (protectLevel - 3'h1);
    end
  end

  // Sector number ignores the top address bit.
  assign targetProtected = {1'b0, addrReg[sfrpe_pkg::SECTOR_LSB +: sfrpe_pkg::SECTOR_W]}
                           >= (sfrpe_pkg::SECTOR_COUNT - protCount);

  assign startProg   = selRise & (state == sfrpe_pkg::ST_PROG_DATA) & (bitCnt == 3'h0) & dataSeen
                       & ~targetProtected & ~busy;
  assign startSector = selRise & (state == sfrpe_pkg::ST_SECTOR_WAIT) & ~targetProtected & ~busy;
  assign startWhole  = selRise & (state == sfrpe_pkg::ST_WHOLE_WAIT) & (protectLevel == 3'h0)
                       & ~busy;

  // ****************************************
  // Self-timed cycle
  // ****************************************
  logic [31:0]                      timer;
  logic [sfrpe_pkg::PAGE_IDX_W-1:0] drainIdx;
  logic                             drainValid;
  logic                             drainReady;
  logic                             drainStep;
  sfrpe_pkg::sfrpe_wr_t             drainWord;

  assign drainValid = (cycState == sfrpe_pkg::CY_DRAIN) & pageMask[drainIdx];
  assign drainStep  = (cycState == sfrpe_pkg::CY_DRAIN) & (~pageMask[drainIdx] | drainReady);
  assign drainWord  = '{addr: {addrReg[sfrpe_pkg::ADDR_W-1:sfrpe_pkg::PAGE_IDX_W], drainIdx},
                        data: pageBuf[drainIdx]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycState <= sfrpe_pkg::CY_IDLE;
      timer    <= '0;
      drainIdx <= '0;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (cycState)
        sfrpe_pkg::CY_IDLE: begin
          drainIdx <= '0;
          if (startProg) begin
            cycState <= sfrpe_pkg::CY_DRAIN;
            timer    <= 32'(PROG_CYCLES);
          end else if (startSector) begin
            cycState <= sfrpe_pkg::CY_WAIT;
            timer    <= 32'(SECTOR_CYCLES);
          end else if (startWhole) begin
            cycState <= sfrpe_pkg::CY_WAIT;
            timer    <= 32'(WHOLE_CYCLES);
          end
        end
        sfrpe_pkg::CY_DRAIN: begin
          if (drainStep) begin
            drainIdx <= drainIdx + 1'b1;
            if (drainIdx == sfrpe_pkg::PAGE_IDX_LAST) begin
              cycState <= sfrpe_pkg::CY_WAIT;
            end
          end
        end
        sfrpe_pkg::CY_WAIT: begin
          if (timer == 32'h0 && !memWrValid) begin
            cycState <= sfrpe_pkg::CY_IDLE;
          end
        end
        default: begin
          cycState <= sfrpe_pkg::CY_IDLE;
        end
      endcase
    end
  end

  sfrpe_fifo #(
    .WIDTH ($bits(sfrpe_pkg::sfrpe_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (drainValid),
    .inReady  (drainReady),
    .inData   (drainWord),
    .outValid (memWrValid),
    .outReady (memWrReady),
    .outData  (memWr)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eraseStart <= 1'b0;
      eraseReq   <= '0;
    end else begin
      eraseStart <= startSector | startWhole;
      if (startSector | startWhole) begin
        eraseReq <= '{whole: startWhole, sector: addrReg[sfrpe_pkg::SECTOR_LSB +: sfrpe_pkg::SECTOR_W]};
      end
    end
  end

  // The latch drops as the cycle starts; a new unlock in the same cycle wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeUnlockLatch <= 1'b0;
    end else if (writeUnlockSet) begin
      writeUnlockLatch <= 1'b1;
    end else if (startProg | startSector | startWhole) begin
      writeUnlockLatch <= 1'b0;
    end
  end

  // ****************************************
  // Output shifting
  // ****************************************
  logic [2:0] outBit;
  logic [6:0] outShift;
  logic       sending;
  logic [7:0] loadByte;

  assign sending  = sclkFall & ((state == sfrpe_pkg::ST_READ_OUT) | (state == sfrpe_pkg::ST_SIG_OUT));
  assign loadByte = (state == sfrpe_pkg::ST_READ_OUT) ? memRdData : SIGNATURE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memRdAddr <= '0;
      outBit    <= '0;
      outShift  <= '0;
      misoOut   <= 1'b0;
      misoOeN   <= 1'b1;
    end else if (deselected) begin
      outBit    <= '0;
      misoOeN   <= 1'b1;
    end else if (addrLast) begin
      memRdAddr <= {addrReg[14:0], inByte};
    end else if (sending) begin
      misoOeN <= 1'b0;
      outBit  <= outBit + 1'b1;
      if (outBit == 3'h0) begin
        misoOut  <= loadByte[7];
        outShift <= loadByte[6:0];
        if (state == sfrpe_pkg::ST_READ_OUT) begin
          memRdAddr <= memRdAddr + 1'b1;
        end
      end else begin
        misoOut  <= outShift[6];
        outShift <= {outShift[5:0], 1'b0};
      end
    end
  end
endmodule

// ### sfrpe_host.sv
`timescale 1ns/1ps
// ********
// Serial host model
// ********
module sfrpe_host (
  // Bench clock
  input  wire logic clk,
  // Serial pins
  input  wire logic miso,
  output logic      sclk,
  output logic      selN,
  output logic      mosi
);
  // The link clock idles low between frames.
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    mosi = 1'b0;
  end

  task automatic half();
    repeat (6) @(negedge clk);
  endtask

  task automatic start();
    half();
    selN = 1'b0;
    half();
  endtask

  // Sends n bits MSB first and samples the reply at each rising edge.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      mosi = tx[i];
      half();
      sclk = 1'b1;
      rx[i] = miso;
      half();
      sclk = 1'b0;
    end
  endtask

  // A released data line shows the inverse of its last bit.
  task automatic stop();
    half();
    selN = 1'b1;
    mosi = ~mosi;
    half();
    half();
  endtask
endmodule

// ### sfrpe_pkg.sv
package sfrpe_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W       = 23;
  localparam int BYTE_W       = 8;
  localparam int PAGE_BYTES   = 256;
  localparam int PAGE_IDX_W   = 8;
  localparam int SECTOR_LSB   = 16;
  localparam int SECTOR_W     = 7;
  localparam int FIFO_DEPTH   = 16;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] PROT_ALL_LEVEL = 3'h7;
  localparam logic [7:0] SECTOR_COUNT   = 8'h80;
  localparam logic [PAGE_IDX_W-1:0] PAGE_IDX_LAST = 8'hFF;
  // Idle levels of the clock, select and data pins, in that order.
  localparam logic [2:0] PIN_IDLE       = 3'h2;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
  localparam logic [7:0] OP_SECTOR_CLEAR = 8'hD8;
  localparam logic [7:0] OP_WHOLE_CLEAR  = 8'hC7;
  localparam logic [7:0] OP_SIGNATURE    = 8'hAB;

  // Signature byte value is arbitrary.
  localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5A;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS      = 4;
  localparam int PROG_TIME_NS       = 1400000;
  localparam int SECTOR_TIME_NS     = 1000000;
  localparam int WHOLE_TIME_NS      = 2000000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_OPCODE      = 4'h0,
    ST_ADDR        = 4'h1,
    ST_DUMMY       = 4'h2,
    ST_READ_OUT    = 4'h3,
    ST_PROG_DATA   = 4'h4,
    ST_SECTOR_WAIT = 4'h5,
    ST_WHOLE_WAIT  = 4'h6,
    ST_SIG_DUMMY   = 4'h7,
    ST_SIG_OUT     = 4'h8,
    ST_IGNORE      = 4'h9
  } sfrpe_state_t;

  typedef enum logic [1:0] {
    CY_IDLE  = 2'h0,
    CY_DRAIN = 2'h1,
    CY_WAIT  = 2'h2
  } sfrpe_cycle_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } sfrpe_wr_t;

  typedef struct packed {
    logic                whole;
    logic [SECTOR_W-1:0] sector;
  } sfrpe_erase_t;

endpackage

// ### tb_sfrpe_core.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; $display("unexpected at %0t: %h", $time, a); end end

module tb_sfrpe_core;
  // Signature value is arbitrary.
  localparam logic [7:0] SIG = 8'hC3;
  logic clk = 1'b0, rst = 1'b1, wus = 1'b0, swb = 1'b0, wrR = 1'b0;
  logic sclk, selN, mosi, miso, oeN, latch, busy, wrV, erS;
  logic [2:0] prot = 3'h0;
  logic [7:0] rdData = 8'h00, rx;
  logic [22:0] rdAddr;
  logic [15:0] lfsr = 16'hB8C2;
  sfrpe_pkg::sfrpe_wr_t wr, w, wrQ [$];
  sfrpe_pkg::sfrpe_erase_t er, e, erQ [$];
  int checked = 0, miscompares = 0, cyc = 0;

  always #2 clk = ~clk;

  sfrpe_host host (.clk, .miso(oeN ? 1'bz : miso), .sclk, .selN, .mosi);
  sfrpe_core #(.PROG_CYCLES(2000), .SECTOR_CYCLES(300), .WHOLE_CYCLES(300), .SIGNATURE(SIG)) DUT (
    .clk, .rst, .sclkPin(sclk), .selectN(selN), .mosiPin(mosi), .misoOut(miso), .misoOeN(oeN),
    .writeUnlockSet(wus), .statusWriteBusy(swb), .protectLevel(prot), .writeUnlockLatch(latch),
    .cycleBusyFlag(busy), .memRdAddr(rdAddr), .memRdData(rdData), .memWrValid(wrV), .memWrReady(wrR),
    .memWr(wr), .eraseStart(erS), .eraseReq(er));

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] memVal(input logic [22:0] a);
    return a[7:0] ^ {1'b0, a[22:16]} ^ 8'h3C;
  endfunction

  // The array answers on the falling clock edge after the address; the program stream stalls at random.
  always @(negedge clk) begin
    lfsr <= lfsrNext(lfsr);
    wrR <= lfsr[0] | lfsr[3];
    rdData <= memVal(rdAddr);
  end

  always @(posedge clk) begin
    if (!rst && wrV && wrR) begin
      w = wrQ.pop_front();
      `CHK(wr, w)
    end
    if (!rst && erS) begin
      e = erQ.pop_front();
      `CHK(er.whole, e.whole)
      if (!e.whole) `CHK(er.sector, e.sector)
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic unlock();
    @(negedge clk) wus = 1'b1;
    @(negedge clk) wus = 1'b0;
  endtask

  task automatic open(input logic [7:0] b [$]);
    host.start();
    foreach (b[i]) host.xfer(b[i], rx, 8);
  endtask

  task automatic idle();
    for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(negedge clk);
    `CHK(busy, 1'b0)
  endtask

  task automatic prog(input logic [23:0] a, input int n, input bit ok);
    logic [7:0] pg [256];
    bit seen [256];
    unlock();
    open('{8'h02, a[23:16], a[15:8], a[7:0]});
    for (int k = 0; k < n; k++) begin
      pg[8'(a[7:0] + k)] = lfsr[15:8];
      seen[8'(a[7:0] + k)] = 1'b1;
      host.xfer(pg[8'(a[7:0] + k)], rx, 8);
    end
    foreach (pg[j]) if (ok && seen[j]) wrQ.push_back({a[22:8], 8'(j), pg[j]});
    host.stop();
    `CHK(busy, ok)
    `CHK(latch, !ok)
  endtask

  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int nb, input bit ul, input bit ok);
    if (ul) unlock();
    open('{op});
    for (int i = 0; i < nb; i++) host.xfer(a[23 - 8 * i -: 8], rx, 8);
    if (ok) erQ.push_back({op == 8'hC7, a[22:16]});
    host.stop();
    `CHK(busy, ok)
    `CHK(latch, ul && !ok)
    idle();
  endtask

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    open('{8'h0B, 8'hFF, 8'hFF, 8'hFF, 8'h00});
    host.xfer(8'h00, rx, 8);
    `CHK(rx, memVal(23'h7FFFFF))
    host.xfer(8'h00, rx, 8);
    `CHK(rx, memVal(23'h000000))
    host.stop();
    `CHK(oeN, 1'b1)
    erase(8'hD8, 24'h8A0000, 3, 1'b0, 1'b0);
    swb = 1'b1;
    @(negedge clk);
    `CHK(busy, 1'b1)
    swb = 1'b0;
    unlock();
    open('{8'h02, 8'h00, 8'h00, 8'h00, 8'hAA});
    host.xfer(8'h55, rx, 4);
    host.stop();
    `CHK(busy, 1'b0)
    prog(24'h0010FE, 3, 1'b1);
    open('{8'h0B, 8'h00, 8'h00, 8'h00, 8'h00});
    host.xfer(8'h00, rx, 8);
    `CHK(oeN, 1'b1)
    host.stop();
    idle();
    prog(24'h000502, 258, 1'b1);
    idle();
    prot = 3'h1;
    prog(24'h7F0000, 1, 1'b0);
    erase(8'hD8, 24'hFA1234, 3, 1'b1, 1'b1);
    erase(8'hD8, 24'h7F0000, 3, 1'b1, 1'b0);
    erase(8'hD8, 24'h100000, 2, 1'b1, 1'b0);
    erase(8'hC7, 24'h000000, 0, 1'b1, 1'b0);
    prot = 3'h7;
    erase(8'hD8, 24'h000000, 3, 1'b1, 1'b0);
    prot = 3'h0;
    erase(8'hC7, 24'h000000, 0, 1'b1, 1'b1);
    open('{8'hAB, 8'h00, 8'h00, 8'h00});
    repeat (2) begin
      host.xfer(8'h00, rx, 8);
      `CHK(rx, SIG)
    end
    host.stop();
    open('{8'hAB, 8'h00, 8'h00, 8'h00});
    host.xfer(8'h00, rx, 3);
    host.stop();
    open('{8'h0B, 8'h00, 8'h01, 8'h23, 8'h00});
    host.xfer(8'h00, rx, 8);
    `CHK(rx, memVal(23'h000123))
    host.stop();
    open('{8'h3E, 8'h00});
    host.xfer(8'h00, rx, 8);
    `CHK(oeN, 1'b1)
    host.stop();
    `CHK(wrQ.size() + erQ.size(), 0)
    finish_test();
  end
endmodule
